// file: rtl/pdm_pkg.sv
// Constants of the power-down mode controller: register map, fields,
// reset values, wait counts and divider terminal counts.
// Assumes a 40 MHz aclk and an AXI4-Lite master with 32-bit data.
`default_nettype none
package pdm_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_FIRST_SC = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_SECOND_SC = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_MOD_STBY = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;
	// ==========================================================
	// Field positions
	localparam int FSC_STANDBY_SELECT = 7;
	localparam int FSC_WAIT_LSB = 4;
	localparam int SSC_SLEEP_KIND_SELECT = 7;
	localparam int SSC_DIRECT_TRANSITION = 5;
	localparam int SSC_DIV_LSB = 2;
	localparam int MSC_SERIAL_UNIT = 5;
	localparam int MSC_ADC = 4;
	localparam int MSC_WATCHDOG = 3;
	localparam int MSC_TIMER_W = 2;
	localparam int MSC_TIMER_V = 1;
	localparam int STAT_DIV_LSB = 3;
	localparam int STAT_WAIT_SHORT = 6;
	// ==========================================================
	// Writable bit masks and reset values
	localparam logic [7:0] FSC_MASK = 8'hF0;
	localparam logic [7:0] SSC_MASK = 8'hBC;
	localparam logic [7:0] MSC_MASK = 8'h3E;
	localparam logic [7:0] FSC_RESET = 8'h00;
	localparam logic [7:0] SSC_RESET = 8'h00;
	localparam logic [7:0] MSC_RESET = 8'h00;
	localparam logic [2:0] DIV_RESET = 3'h0;
	// ==========================================================
	// Stabilisation wait counts in system clock states
	localparam int WAIT_W = 18;
	localparam logic [WAIT_W-1:0] WAIT_8192 = 18'h02000;
	localparam logic [WAIT_W-1:0] WAIT_16384 = 18'h04000;
	localparam logic [WAIT_W-1:0] WAIT_32768 = 18'h08000;
	localparam logic [WAIT_W-1:0] WAIT_65536 = 18'h10000;
	localparam logic [WAIT_W-1:0] WAIT_131072 = 18'h20000;
	localparam logic [WAIT_W-1:0] WAIT_1024 = 18'h00400;
	localparam logic [WAIT_W-1:0] WAIT_128 = 18'h00080;
	localparam logic [WAIT_W-1:0] WAIT_16 = 18'h00010;
	// Least stabilisation time and its cycle count at aclk rate
	localparam int CLK_KHZ = 40000;
	localparam int MIN_STABLE_US = 6500;
	localparam int MIN_STABLE_CYCLES = (MIN_STABLE_US * CLK_KHZ + 999) / 1000;
	// ==========================================================
	// Divider terminal counts (ratio minus one)
	localparam logic [5:0] DIV_TERM_1 = 6'h00;
	localparam logic [5:0] DIV_TERM_8 = 6'h07;
	localparam logic [5:0] DIV_TERM_16 = 6'h0F;
	localparam logic [5:0] DIV_TERM_32 = 6'h1F;
	localparam logic [5:0] DIV_TERM_64 = 6'h3F;
	// ==========================================================
	// Bus responses and status mode codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] MODE_ACTIVE = 3'h0;
	localparam logic [2:0] MODE_SLEEP = 3'h1;
	localparam logic [2:0] MODE_SUBSLEEP = 3'h2;
	localparam logic [2:0] MODE_STANDBY = 3'h3;
	localparam logic [2:0] MODE_STABILISE = 3'h4;
endpackage
`default_nettype wire

// file: rtl/pdm_power_down_mode_control.sv
// Power-down mode controller: mode selection on a sleep request,
// system clock divider, standby-exit stabilisation wait, module standby.
// Assumes sleep_req and wake_irq come from same-clock logic.
// Function
// - Wait select code maps to 8192,16384,32768,65536,131072,1024,128,16 states.
// - After interrupt exit from standby, hold CPU and peripherals for that count.
// - Sleep kind select bit 7 of second control, reset 0, read/write.
// - Direct transition flag bit 5 of second control, reset 0, read/write.
// - Sleep request enters sleep, subsleep, standby or direct change; interrupts return active.
// - Divider bits 4:2 reset 000: 0xx undivided, 100 /8, 101 /16.
// - Divider codes 110 and 111 give /32 and /64.
// - Writing the divider field changes the clock only after a sleep request.
// - Reserved bits of second control and module standby read as zero.
// - Module standby bit 5 halts the serial unit.
// - Module standby bit 4 halts the converter.
// - Module standby bit 3 halts the watchdog unless wdt_internal_osc is set.
// - Module standby bit 2 halts timer W.
// - Module standby bit 1 halts timer V.
`timescale 1ns/10ps
`default_nettype none
module pdm_power_down_mode_control #(
	parameter logic [17:0] WAIT_CODE0 = pdm_pkg::WAIT_8192,
	parameter logic [17:0] WAIT_CODE1 = pdm_pkg::WAIT_16384,
	parameter logic [17:0] WAIT_CODE2 = pdm_pkg::WAIT_32768,
	parameter logic [17:0] WAIT_CODE3 = pdm_pkg::WAIT_65536,
	parameter logic [17:0] WAIT_CODE4 = pdm_pkg::WAIT_131072,
	parameter int MIN_STABLE_CYCLES = pdm_pkg::MIN_STABLE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_req,
	input wire logic wake_irq,
	input wire logic wdt_internal_osc,
	output logic cpu_halt,
	output logic periph_halt,
	output logic osc_run,
	output logic sys_tick,
	output logic irq_release,
	output logic serial_clk_en,
	output logic adc_clk_en,
	output logic wdt_clk_en,
	output logic timer_w_clk_en,
	output logic timer_v_clk_en
);
	// ==========================================================
	// Types and functions
	typedef enum logic [2:0] {
		PDM_ACTIVE, PDM_SLEEP, PDM_SUBSLEEP, PDM_STANDBY, PDM_STABILISE
	} pdm_state_t;

	// Wait code to last state index (count minus one)
	function automatic logic [17:0] wait_last(input logic [2:0] code);
		logic [17:0] n;
		n = pdm_pkg::WAIT_16;
		unique case (code)
			3'h0: n = WAIT_CODE0;
			3'h1: n = WAIT_CODE1;
			3'h2: n = WAIT_CODE2;
			3'h3: n = WAIT_CODE3;
			3'h4: n = WAIT_CODE4;
			3'h5: n = pdm_pkg::WAIT_1024;
			3'h6: n = pdm_pkg::WAIT_128;
			3'h7: n = pdm_pkg::WAIT_16;
		endcase
		return n - 18'h00001;
	endfunction

	// Divider code to terminal count of the tick divider
	function automatic logic [5:0] div_term(input logic [2:0] code);
		logic [5:0] t;
		unique case (code)
			3'h4: t = pdm_pkg::DIV_TERM_8;
			3'h5: t = pdm_pkg::DIV_TERM_16;
			3'h6: t = pdm_pkg::DIV_TERM_32;
			3'h7: t = pdm_pkg::DIV_TERM_64;
			default: t = pdm_pkg::DIV_TERM_1; // 0xx runs undivided
		endcase
		return t;
	endfunction

	// ==========================================================
	// State
	logic [7:0] first_sc_q;
	logic [7:0] second_sc_q;
	logic [7:0] mod_stby_q;
	logic [2:0] div_applied_q;
	logic [5:0] div_cnt_q;
	logic [17:0] wait_cnt_q;
	pdm_state_t state_q;
	pdm_state_t state_d;
	logic irq_release_q;
	logic tick_q;
	logic [4:0] mod_en_q;
	logic aw_full_q;
	logic w_full_q;
	logic [3:0] aw_addr_q;
	logic [7:0] w_byte_q;
	logic w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// ==========================================================
	// Register fields
	wire standby_select = first_sc_q[pdm_pkg::FSC_STANDBY_SELECT];
	wire [2:0] wait_select = first_sc_q[pdm_pkg::FSC_WAIT_LSB +: 3];
	wire sleep_kind_select = second_sc_q[pdm_pkg::SSC_SLEEP_KIND_SELECT];
	wire direct_transition_flag = second_sc_q[pdm_pkg::SSC_DIRECT_TRANSITION];
	wire [2:0] clock_div_sel = second_sc_q[pdm_pkg::SSC_DIV_LSB +: 3];

	// ==========================================================
	// Mode sequencing
	wire in_active = (state_q == PDM_ACTIVE);
	wire take_sleep = in_active && sleep_req;
	wire direct_change = direct_transition_flag && !sleep_kind_select;
	wire [17:0] wait_end = wait_last(wait_select);
	wire wait_done = (state_q == PDM_STABILISE) && tick_q && (wait_cnt_q == wait_end);
	wire wake_now = wake_irq && ((state_q == PDM_SLEEP) || (state_q == PDM_SUBSLEEP));
	pdm_state_t sleep_target;
	assign sleep_target = standby_select ? PDM_STANDBY : (sleep_kind_select ? PDM_SUBSLEEP : PDM_SLEEP);

	// Next mode; a direct change stays active and only swaps the clock
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PDM_ACTIVE: state_d = (sleep_req && !direct_change) ? sleep_target : state_q;
			PDM_SLEEP, PDM_SUBSLEEP: state_d = wake_irq ? PDM_ACTIVE : state_q;
			PDM_STANDBY: state_d = wake_irq ? PDM_STABILISE : state_q;
			PDM_STABILISE: state_d = wait_done ? PDM_ACTIVE : state_q;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= PDM_ACTIVE;
		end else begin
			state_q <= state_d;
		end
	end

	// The divider field reaches the clock only at a sleep request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_applied_q <= pdm_pkg::DIV_RESET;
		end else if (take_sleep) begin
			div_applied_q <= clock_div_sel;
		end
	end

	// ==========================================================
	// System clock tick, stopped while the oscillator is halted
	wire osc_on = (state_q != PDM_STANDBY) && (state_q != PDM_SUBSLEEP);
	wire div_wrap = (div_cnt_q == div_term(div_applied_q));

	always_ff @(posedge aclk) begin
		if (!aresetn || !osc_on || div_wrap) begin
			div_cnt_q <= 6'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 6'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= osc_on && div_wrap;
		end
	end

	// Wait counter is held at zero outside stabilisation and counts ticks only after a standby exit
	always_ff @(posedge aclk) begin
		if (!aresetn || (state_q != PDM_STABILISE)) begin
			wait_cnt_q <= 18'h00000;
		end else if (tick_q) begin
			wait_cnt_q <= wait_cnt_q + 18'h00001;
		end
	end

	// Interrupt handling starts after the wait or on a sleep wake-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_release_q <= 1'b0;
		end else begin
			irq_release_q <= wait_done || wake_now;
		end
	end

	// Short setting warning: wait in aclk cycles below the least time
	wire [24:0] wait_cycles = (25'(wait_end) + 25'h0000001) * (25'(div_term(div_applied_q)) + 25'h0000001);
	wire wait_short = (wait_cycles < 25'(MIN_STABLE_CYCLES));

	// ==========================================================
	// Module clock enables, registered so gating is glitch free
	wire run_periph = (state_q == PDM_ACTIVE) || (state_q == PDM_SLEEP);
	wire [4:0] mod_en_d = {
		run_periph && !mod_stby_q[pdm_pkg::MSC_SERIAL_UNIT],
		run_periph && !mod_stby_q[pdm_pkg::MSC_ADC],
		wdt_internal_osc || (run_periph && !mod_stby_q[pdm_pkg::MSC_WATCHDOG]),
		run_periph && !mod_stby_q[pdm_pkg::MSC_TIMER_W],
		run_periph && !mod_stby_q[pdm_pkg::MSC_TIMER_V]
	};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mod_en_q <= 5'h1F;
		end else begin
			mod_en_q <= mod_en_d;
		end
	end

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	wire do_write = aw_full_q && w_full_q && !bvalid_q;
	wire wr_first = (aw_addr_q == pdm_pkg::OFS_FIRST_SC);
	wire wr_second = (aw_addr_q == pdm_pkg::OFS_SECOND_SC);
	wire wr_mstby = (aw_addr_q == pdm_pkg::OFS_MOD_STBY);
	wire wr_hit = wr_first || wr_second || wr_mstby || (aw_addr_q == pdm_pkg::OFS_STATUS);
	wire wr_en = do_write && w_strb_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_byte_q <= 8'h00;
			w_strb_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[3:2], 2'h0};
			end else if (do_write) begin
				aw_full_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_byte_q <= s_axi_wdata[7:0];
				w_strb_q <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// Reserved positions are masked so stray writes leave them zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_sc_q <= pdm_pkg::FSC_RESET;
			second_sc_q <= pdm_pkg::SSC_RESET;
			mod_stby_q <= pdm_pkg::MSC_RESET;
		end else if (wr_en) begin
			if (wr_first) begin
				first_sc_q <= w_byte_q & pdm_pkg::FSC_MASK;
			end
			if (wr_second) begin
				second_sc_q <= w_byte_q & pdm_pkg::SSC_MASK;
			end
			if (wr_mstby) begin
				mod_stby_q <= w_byte_q & pdm_pkg::MSC_MASK;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= pdm_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read path, one cycle after the address is taken
	wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'h0};
	wire [2:0] mode_code = (state_q == PDM_SLEEP) ? pdm_pkg::MODE_SLEEP :
		(state_q == PDM_SUBSLEEP) ? pdm_pkg::MODE_SUBSLEEP :
		(state_q == PDM_STANDBY) ? pdm_pkg::MODE_STANDBY :
		(state_q == PDM_STABILISE) ? pdm_pkg::MODE_STABILISE : pdm_pkg::MODE_ACTIVE;
	wire [7:0] status_byte = {1'b0, wait_short, div_applied_q, mode_code};
	wire rd_hit = (rd_addr == pdm_pkg::OFS_FIRST_SC) || (rd_addr == pdm_pkg::OFS_SECOND_SC) ||
		(rd_addr == pdm_pkg::OFS_MOD_STBY) || (rd_addr == pdm_pkg::OFS_STATUS);
	wire [7:0] rd_byte = (rd_addr == pdm_pkg::OFS_FIRST_SC) ? first_sc_q :
		(rd_addr == pdm_pkg::OFS_SECOND_SC) ? (second_sc_q & pdm_pkg::SSC_MASK) :
		(rd_addr == pdm_pkg::OFS_MOD_STBY) ? (mod_stby_q & pdm_pkg::MSC_MASK) :
		(rd_addr == pdm_pkg::OFS_STATUS) ? status_byte : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= pdm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h000000, rd_byte};
			rresp_q <= rd_hit ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign {s_axi_bvalid, s_axi_bresp} = {bvalid_q, bresp_q};
	assign s_axi_arready = !rvalid_q;
	assign {s_axi_rvalid, s_axi_rresp, s_axi_rdata} = {rvalid_q, rresp_q, rdata_q};
	assign {cpu_halt, periph_halt, osc_run} = {!in_active, !run_periph, osc_on};
	assign {sys_tick, irq_release} = {tick_q, irq_release_q};
	assign {serial_clk_en, adc_clk_en, wdt_clk_en, timer_w_clk_en, timer_v_clk_en} = mod_en_q;
endmodule
`default_nettype wire

// file: verif/pdm_power_down_mode_control_chk.sv
// Port checker for the power-down mode controller.
// Assumes one clock domain and binding into the design top.
`timescale 1ns/10ps
`default_nettype none
module pdm_power_down_mode_control_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wake_irq,
	input wire logic wdt_internal_osc,
	input wire logic cpu_halt,
	input wire logic periph_halt,
	input wire logic osc_run,
	input wire logic irq_release,
	input wire logic serial_clk_en,
	input wire logic adc_clk_en,
	input wire logic wdt_clk_en,
	input wire logic timer_w_clk_en,
	input wire logic timer_v_clk_en
);
	// ==========================================
	// Shared clock and reset for every property
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_hold:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early");
	a_rdata_hold:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped early");
	a_read_excl:
		assert property (s_axi_arready == !s_axi_rvalid)
		else $error("Read address accepted during pending data");
	a_upper_zero:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("Unused read bits not zero");
	a_osc_off_halts:
		assert property (!osc_run |-> cpu_halt && periph_halt)
		else $error("Oscillator off while something runs");
	a_wake_sleep:
		assert property (cpu_halt && !periph_halt && wake_irq |-> ##[1:2] (irq_release && !cpu_halt))
		else $error("Sleep not left on interrupt");
	a_release_pulse:
		assert property (irq_release |=> !irq_release)
		else $error("Interrupt release longer than one cycle");
	a_release_after_halt:
		assert property (irq_release |-> $past(cpu_halt) || $past(cpu_halt, 2))
		else $error("Interrupt release without prior halt");
	a_halt_gates:
		assert property (periph_halt && $past(periph_halt) |-> !(serial_clk_en | adc_clk_en | timer_w_clk_en
			| timer_v_clk_en))
		else $error("Peripheral clock runs while halted");
	a_wdt_internal:
		assert property ($past(wdt_internal_osc) |-> wdt_clk_en)
		else $error("Watchdog stopped on internal oscillator");
endmodule
bind pdm_power_down_mode_control pdm_power_down_mode_control_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .wake_irq(wake_irq), .wdt_internal_osc(wdt_internal_osc),
	.cpu_halt(cpu_halt), .periph_halt(periph_halt), .osc_run(osc_run), .irq_release(irq_release),
	.serial_clk_en(serial_clk_en), .adc_clk_en(adc_clk_en), .wdt_clk_en(wdt_clk_en),
	.timer_w_clk_en(timer_w_clk_en), .timer_v_clk_en(timer_v_clk_en));
`default_nettype wire

// file: verif/tb_power_down_mode_control.sv
// Self-checking bench for the power-down mode controller.
// Assumes short wait parameters for codes 1 to 4 so those standby exits stay brief.
`timescale 1ns/10ps
`default_nettype none
module tb_power_down_mode_control;
	logic aclk, awready, wready, bvalid, arready, rvalid, cpu_halt, periph_halt, osc_run, sys_tick, irq_release;
	logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sleep_req = 1'b0, wake_irq = 1'b0, wdt_osc = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [4:0] clk_en;
	int fail_count, total_checks;
	int waits[8] = '{8192, 24, 28, 32, 40, 1024, 128, 16};
	// Codes 1 to 4 are shortened; code 0 keeps its full count of 8192 states; the least time is cut to 100 cycles
	pdm_power_down_mode_control #(.WAIT_CODE1(18'h00018), .WAIT_CODE2(18'h0001C),
		.WAIT_CODE3(18'h00020), .WAIT_CODE4(18'h00028), .MIN_STABLE_CYCLES(100)) uut (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_req(sleep_req), .wake_irq(wake_irq),
		.wdt_internal_osc(wdt_osc), .cpu_halt(cpu_halt), .periph_halt(periph_halt), .osc_run(osc_run),
		.sys_tick(sys_tick), .irq_release(irq_release), .serial_clk_en(clk_en[4]), .adc_clk_en(clk_en[3]),
		.wdt_clk_en(clk_en[2]), .timer_w_clk_en(clk_en[1]), .timer_v_clk_en(clk_en[0]));
	// ==========================================
	// Clock and run limit
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		report_and_stop;
	end
	// ==========================================
	// Helpers; every task that waits on the clock starts and ends just after a rising edge
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function automatic int ratio(input int c);
		return c < 4 ? 1 : 8 << (c - 4);
	endfunction
	// Readiness is judged at the falling edge, so the taking edge is the next rise
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bit aw;
		bit w;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 0;
		w = 0;
		while (!(aw && w)) begin
			@(negedge aclk);
			aw = aw | awready;
			w = w | wready;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		@(negedge aclk);
		while (!bvalid) @(negedge aclk);
		chk({30'h0, bresp}, 32'h0);
		@(posedge aclk);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge aclk);
		while (!arready) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'b0;
		@(negedge aclk);
		while (!rvalid) @(negedge aclk);
		chk(rdata, e);
		chk({30'h0, rresp}, 32'h0);
		@(posedge aclk);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic slp;
		sleep_req <= 1'b1;
		@(posedge aclk);
		sleep_req <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	// Halt, peripheral halt and oscillator flags as one triple
	task automatic st(input logic [2:0] e);
		@(negedge aclk);
		chk({29'h0, cpu_halt, periph_halt, osc_run}, {29'h0, e});
		@(posedge aclk);
	endtask
	task automatic ticks(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge aclk);
			if (sys_tick) c++;
		end
		@(posedge aclk);
	endtask
	// Standby with wait code c; the exit time must cover the count in system states
	task automatic stby(input int c, input int r);
		int n;
		wr(4'h0, {1'b1, c[2:0], 4'h0});
		slp;
		st(3'b110);
		wake_irq <= 1'b1;
		@(posedge aclk);
		wake_irq <= 1'b0;
		n = 0;
		@(negedge aclk);
		while (!irq_release && n < 9000) begin
			@(negedge aclk);
			n++;
		end
		chk(n >= waits[c] * r && n <= waits[c] * r + r + 4, 1);
		@(posedge aclk);
		st(3'b001);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs;
		rchk(4'h4, 32'h0);
		rchk(4'h8, 32'h0);
		wr(4'h4, 8'hFF);
		rchk(4'h4, 32'hBC);
		// A write with byte lane 0 off must leave the register alone
		wstrb <= 4'h0;
		wr(4'h4, 8'h00);
		rchk(4'h4, 32'hBC);
		wstrb <= 4'hF;
		wr(4'h8, 8'hFF);
		rchk(4'h8, 32'h3E);
		wr(4'hC, 8'hFF);
		rchk(4'hC, 32'h00);
		wr(4'h8, 8'h00);
	endtask
	task automatic t_mstby;
		for (int b = 1; b <= 5; b++) begin
			wr(4'h8, 8'h01 << b);
			repeat (2) @(posedge aclk);
			chk({27'h0, clk_en}, {27'h0, ~(5'h01 << (b - 1))});
		end
		wdt_osc <= 1'b1;
		wr(4'h8, 8'h08);
		repeat (2) @(posedge aclk);
		chk({27'h0, clk_en}, 32'h1F);
		wdt_osc <= 1'b0;
		wr(4'h8, 8'h00);
	endtask
	// Divider only moves on a sleep request; direct change stays active
	task automatic t_div;
		int n;
		int prev;
		bit ws;
		prev = 1;
		// Shortest wait code, so the short-wait flag changes with the ratio
		wr(4'h0, 8'h70);
		for (int c = 0; c < 8; c++) begin
			wr(4'h4, {3'h1, c[2:0], 2'h0});
			ticks(128, n);
			chk(n, 128 / prev);
			slp;
			st(3'b001);
			ticks(128, n);
			chk(n, 128 / ratio(c));
			ws = waits[7] * ratio(c) < 100;
			rchk(4'hC, {25'h0, ws, c[2:0], 3'h0});
			prev = ratio(c);
		end
	endtask
	task automatic t_sleep;
		wr(4'h0, 8'h00);
		wr(4'h4, 8'h00);
		slp;
		st(3'b101);
		wake_irq <= 1'b1;
		@(posedge aclk);
		wake_irq <= 1'b0;
		repeat (2) @(posedge aclk);
		st(3'b001);
		wr(4'h4, 8'h80);
		slp;
		st(3'b110);
		wake_irq <= 1'b1;
		@(posedge aclk);
		wake_irq <= 1'b0;
		repeat (2) @(posedge aclk);
		st(3'b001);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_mstby;
		t_div;
		t_sleep;
		for (int c = 0; c < 8; c++) stby(c, 1);
		// Divide by 8 with the direct flag clear, so the sleep request still enters standby
		wr(4'h4, 8'h10);
		stby(7, 8);
		report_and_stop;
	end
endmodule
`default_nettype wire
